// ==== hw/rtcat_alarm_stamp.sv ====
// Purpose: Alarm compare with open-drain interrupt pin, and first switchover time stamp
// Assumes: Calendar bytes are valid in the cycle that sec_tick pulses
// Notes:   Frequency synthesis lives elsewhere; only its waveform is steered onto the pin
//
// Behaviour
// - Alarm bytes use calendar formats for seconds, minutes, hours, date, month, weekday.
// - Top bit of each alarm byte enables that field's comparison.
// - Enabled alarm fields are compared as time advances; all matching triggers alarm.
// - Any non-empty set of fields may be enabled; match uses exactly that set.
// - No year alarm field; year never compared.
// - Single mode with frequency off: match sets alarm flag and pulls pin low.
// - Single mode with frequency off: pin stays low until alarm flag is cleared.
// - Pulsed mode with frequency off: pin pulses on every match.
// - Pulsed mode still sets alarm flag; clearing it is not needed.
// - With auto clear set, reading status clears the alarm flag.
// - Time stamp holds seconds through month in calendar formats.
// - Only first switchover to battery is stamped until the bank is cleared.
// - Writing one to stamp clear in supply control clears and re-arms stamp.
// - Stamp clear sets every stamp byte to zero.
`timescale 1ns/1ps
module rtcat_alarm_stamp (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // Register port
    input  wire rtcat_pkg::rtcat_req_s reg_req,
    output logic [7:0]                reg_rdata,
    // Calendar
    input  wire logic                 sec_tick,
    input  wire rtcat_pkg::rtcat_cal_t cal_now,
    // Power source
    input  wire logic                 on_battery,
    // Frequency waveform from divider
    input  wire logic                 fout_wave,
    // Interrupt or clock pin, open drain
    input  wire logic                 irq_pin_in,
    output logic                      irq_pin_out,
    output logic                      irq_pin_oe
);

    rtcat_pkg::rtcat_state_s st_reg;
    rtcat_pkg::rtcat_state_s st_next;
    logic [rtcat_pkg::N_ALARM-1:0] field_ok;
    logic [rtcat_pkg::N_ALARM-1:0] field_en;
    logic                          any_en;
    logic                          hit;
    logic                          freq_on;
    logic                          batt_rise;
    logic                          stamp_clr;
    logic                          status_rd;

    // Offset decode shared by reads and writes of a bank
    function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base,
                                     input int n);
        return (a >= base) && ({24'h0000_00, a} < ({24'h0000_00, base} + n[31:0]));
    endfunction : in_bank

    // Per-field compare; year has no alarm byte so it never takes part
    genvar gi;
    generate
        for (gi = 0; gi < rtcat_pkg::N_ALARM; gi++) begin : g_field
            assign field_en[gi] = st_reg.alarm[gi][rtcat_pkg::BIT_ENABLE];
            assign field_ok[gi] = !field_en[gi] ||
                (st_reg.alarm[gi][6:0] == cal_now[gi][6:0]);
        end
    endgenerate

    // Trigger needs at least one enabled field, and every enabled one matching
    assign any_en    = |field_en;
    assign hit       = sec_tick && any_en && (&field_ok);
    assign freq_on   = |st_reg.fo;
    assign batt_rise = on_battery && !st_reg.batt_prev;
    assign stamp_clr = reg_req.wr && (reg_req.addr == rtcat_pkg::ADDR_SUPPLY) &&
                       reg_req.wdata[rtcat_pkg::BIT_STAMP_CLEAR];
    assign status_rd = reg_req.rd && (reg_req.addr == rtcat_pkg::ADDR_STATUS);

    // Next-state logic
    always_comb begin
        st_next           = st_reg;
        st_next.batt_prev = on_battery;
        // Register writes
        if (reg_req.wr) begin
            if (in_bank(reg_req.addr, rtcat_pkg::ADDR_ALARM_BASE, rtcat_pkg::N_ALARM)) begin
                st_next.alarm[reg_req.addr - rtcat_pkg::ADDR_ALARM_BASE] = reg_req.wdata;
            end
            if (reg_req.addr == rtcat_pkg::ADDR_INT_CTRL) begin
                st_next.auto_clear_on_read = reg_req.wdata[rtcat_pkg::BIT_AUTO_CLEAR];
                st_next.im   = reg_req.wdata[rtcat_pkg::BIT_PULSED];
                st_next.fo   = reg_req.wdata[rtcat_pkg::FO_LSB +: rtcat_pkg::FO_W];
            end
            if ((reg_req.addr == rtcat_pkg::ADDR_STATUS) &&
                !reg_req.wdata[rtcat_pkg::BIT_ALARM_FLAG]) begin
                st_next.alarm_flag = 1'b0;
            end
        end
        // Read-side effect; the stamp clear bit reads back as zero
        if (reg_req.rd) begin
            st_next.rdata = rtcat_pkg::ZERO_BYTE;
            if (in_bank(reg_req.addr, rtcat_pkg::ADDR_ALARM_BASE, rtcat_pkg::N_ALARM)) begin
                st_next.rdata = st_reg.alarm[reg_req.addr - rtcat_pkg::ADDR_ALARM_BASE];
            end
            if (in_bank(reg_req.addr, rtcat_pkg::ADDR_STAMP_BASE, rtcat_pkg::N_STAMP)) begin
                st_next.rdata = st_reg.stamp[reg_req.addr - rtcat_pkg::ADDR_STAMP_BASE];
            end
            if (reg_req.addr == rtcat_pkg::ADDR_STATUS) begin
                st_next.rdata[rtcat_pkg::BIT_ALARM_FLAG] = st_reg.alarm_flag;
            end
            if (reg_req.addr == rtcat_pkg::ADDR_INT_CTRL) begin
                st_next.rdata[rtcat_pkg::BIT_AUTO_CLEAR] = st_reg.auto_clear_on_read;
                st_next.rdata[rtcat_pkg::BIT_PULSED]     = st_reg.im;
                st_next.rdata[rtcat_pkg::FO_LSB +: rtcat_pkg::FO_W] = st_reg.fo;
            end
        end
        if (status_rd && st_reg.auto_clear_on_read) begin
            st_next.alarm_flag = 1'b0;
        end
        // Pulse timer runs down after each pulsed-mode match
        if (st_reg.pulse_cnt != '0) begin
            st_next.pulse_cnt = st_reg.pulse_cnt - 1'b1;
        end
        // Match placed last so a trigger beats a same-cycle clear
        if (hit) begin
            st_next.alarm_flag = 1'b1;
            if (st_reg.im) begin
                st_next.pulse_cnt = rtcat_pkg::PULSE_W'(rtcat_pkg::PULSE_CYC);
            end
        end
        // Clear empties the bank and re-arms capture
        if (stamp_clr) begin
            st_next.stamp       = '0;
            st_next.stamp_taken = 1'b0;
        end
        // Capture after clear, so a switchover in the clear cycle is kept
        if (batt_rise && (!st_reg.stamp_taken || stamp_clr)) begin
            for (int i = 0; i < rtcat_pkg::N_STAMP; i++) begin
                st_next.stamp[i] = cal_now[i];
            end
            st_next.stamp_taken = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg             <= '0;
            st_reg.alarm       <= {rtcat_pkg::N_ALARM{rtcat_pkg::ALARM_RST}};
            st_reg.stamp       <= {rtcat_pkg::N_STAMP{rtcat_pkg::STAMP_RST}};
        end else begin
            st_reg <= st_next;
        end
    end

    // Pin: frequency output owns it when selected, else alarm drives it low
    always_comb begin
        irq_pin_out = 1'b0;
        if (freq_on) begin
            irq_pin_oe = !fout_wave;
        end else if (st_reg.im) begin
            irq_pin_oe = (st_reg.pulse_cnt != '0);
        end else begin
            irq_pin_oe = st_reg.alarm_flag;
        end
    end

    assign reg_rdata = st_reg.rdata;

    // Pin readback is not needed; it only mirrors the bus level
    logic unused_pin;
    assign unused_pin = irq_pin_in;

    // Checks
    localparam int PW      = rtcat_pkg::PULSE_CYC;
    // Gap from the eighth counted cycle to the first cycle with the pin released
    localparam int PW_TAIL = rtcat_pkg::PULSE_CYC - 7;
    logic pulsed_cfg;
    logic flag_wr_clr;
    logic ctrl_wr;
    assign pulsed_cfg  = st_reg.im && !freq_on;
    // Host requests that may legally drop the flag or hand the pin elsewhere
    assign flag_wr_clr = reg_req.wr && (reg_req.addr == rtcat_pkg::ADDR_STATUS) &&
                         !reg_req.wdata[rtcat_pkg::BIT_ALARM_FLAG];
    assign ctrl_wr     = reg_req.wr && (reg_req.addr == rtcat_pkg::ADDR_INT_CTRL);

    // Single mode: once low, the pin stays low until a clear or a mode change is taken
    property p_single_low;
        @(posedge clk) disable iff (sys_rst)
        (st_reg.alarm_flag && !st_reg.im && !freq_on && !flag_wr_clr && !ctrl_wr &&
         !(status_rd && st_reg.auto_clear_on_read)) |=> irq_pin_oe;
    endproperty
    a_single_low: assert property (p_single_low) else $error("pin released while flag set");

    property p_hit_sets_flag;
        @(posedge clk) disable iff (sys_rst)
        hit |=> st_reg.alarm_flag;
    endproperty
    a_hit_sets_flag: assert property (p_hit_sets_flag) else $error("match lost flag");

    property p_pulse_width;
        @(posedge clk) disable iff (sys_rst)
        (hit && pulsed_cfg) |=> irq_pin_oe[*8] ##[PW_TAIL:PW_TAIL] (!irq_pin_oe || $past(hit));
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");

    property p_pulse_each;
        @(posedge clk) disable iff (sys_rst)
        (hit && pulsed_cfg) |=> (st_reg.alarm_flag && st_reg.pulse_cnt == rtcat_pkg::PULSE_W'(PW));
    endproperty
    a_pulse_each: assert property (p_pulse_each) else $error("pulsed match missed");

    property p_no_enable_no_alarm;
        @(posedge clk) disable iff (sys_rst)
        (!any_en && !st_reg.alarm_flag) |=> !st_reg.alarm_flag;
    endproperty
    a_no_enable_no_alarm: assert property (p_no_enable_no_alarm)
        else $error("alarm with no field enabled");

    property p_auto_clear;
        @(posedge clk) disable iff (sys_rst)
        (status_rd && st_reg.auto_clear_on_read && !hit) |=> !st_reg.alarm_flag;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("read did not clear flag");

    property p_stamp_clear;
        @(posedge clk) disable iff (sys_rst)
        (stamp_clr && !batt_rise) |=> (st_reg.stamp == '0 && !st_reg.stamp_taken);
    endproperty
    a_stamp_clear: assert property (p_stamp_clear) else $error("stamp not cleared");

    property p_first_capture;
        @(posedge clk) disable iff (sys_rst)
        (batt_rise && !st_reg.stamp_taken) |=>
            (st_reg.stamp == $past(cal_now[rtcat_pkg::N_STAMP-1:0]) && st_reg.stamp_taken);
    endproperty
    a_first_capture: assert property (p_first_capture) else $error("capture wrong");

    property p_later_ignored;
        @(posedge clk) disable iff (sys_rst)
        (st_reg.stamp_taken && !stamp_clr) |=> $stable(st_reg.stamp);
    endproperty
    a_later_ignored: assert property (p_later_ignored) else $error("stamp overwritten");

    // A clearing write drops the flag unless a match lands in the same cycle
    property p_flag_write_clear;
        @(posedge clk) disable iff (sys_rst)
        (flag_wr_clr && !hit) |=> !st_reg.alarm_flag;
    endproperty
    a_flag_write_clear: assert property (p_flag_write_clear)
        else $error("write did not clear flag");

    // Without a calendar tick nothing may raise the flag
    property p_quiet_no_flag;
        @(posedge clk) disable iff (sys_rst)
        (!sec_tick && !st_reg.alarm_flag) |=> !st_reg.alarm_flag;
    endproperty
    a_quiet_no_flag: assert property (p_quiet_no_flag)
        else $error("flag set without tick");

    // The last counted pulse cycle is followed by a released pin
    property p_pulse_ends;
        @(posedge clk) disable iff (sys_rst)
        (pulsed_cfg && st_reg.pulse_cnt == rtcat_pkg::PULSE_W'(1) && !hit && !ctrl_wr) |=>
            !irq_pin_oe;
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("pulse too long");

    // Control writes land whole in the mode bits
    property p_ctrl_write;
        @(posedge clk) disable iff (sys_rst)
        ctrl_wr |=> (st_reg.im == $past(reg_req.wdata[rtcat_pkg::BIT_PULSED]) &&
                     st_reg.fo == $past(reg_req.wdata[rtcat_pkg::FO_LSB +: rtcat_pkg::FO_W]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    // Read data stands until the next read is taken, so a slow host still sees it
    property p_rdata_hold;
        @(posedge clk) disable iff (sys_rst)
        !reg_req.rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    // Main scenarios the bench is expected to reach

    c_single: cover property (@(posedge clk) disable iff (sys_rst)
        hit && !st_reg.im ##1 irq_pin_oe);
    c_pulsed: cover property (@(posedge clk) disable iff (sys_rst)
        hit && pulsed_cfg ##1 irq_pin_oe[*8]);
    c_capture: cover property (@(posedge clk) disable iff (sys_rst)
        batt_rise && !st_reg.stamp_taken);
    c_rearm: cover property (@(posedge clk) disable iff (sys_rst)
        stamp_clr && st_reg.stamp_taken);
    c_auto_clear: cover property (@(posedge clk) disable iff (sys_rst)
        status_rd && st_reg.auto_clear_on_read && st_reg.alarm_flag);

endmodule : rtcat_alarm_stamp

// ==== include/rtcat_pkg.sv ====
// Purpose: Shared constants and types for the alarm and time-stamp block
// Assumes: Byte-wide register port, 40 MHz clock
// Notes:   Field index 0 is seconds, rising through minutes, hours, date, month, weekday
package rtcat_pkg;

    // Clock and pulse timing
    localparam int          CLK_NS          = 25;
    localparam int          PULSE_NS        = 500;
    localparam int          PULSE_CYC       = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          PULSE_W         = 5;

    // Register offsets
    localparam logic [7:0]  ADDR_STATUS     = 8'h07;
    localparam logic [7:0]  ADDR_INT_CTRL   = 8'h08;
    localparam logic [7:0]  ADDR_SUPPLY     = 8'h09;
    localparam logic [7:0]  ADDR_ALARM_BASE = 8'h10;
    localparam logic [7:0]  ADDR_STAMP_BASE = 8'h16;
    localparam int          N_ALARM         = 6;
    localparam int          N_STAMP         = 5;

    // Bit positions
    localparam int          BIT_ENABLE      = 7;
    localparam int          BIT_ALARM_FLAG  = 4;
    localparam int          BIT_AUTO_CLEAR  = 7;
    localparam int          BIT_PULSED      = 6;
    localparam int          BIT_STAMP_CLEAR = 7;
    localparam int          FO_LSB          = 0;
    localparam int          FO_W            = 4;

    // Reset values
    localparam logic [7:0]  ALARM_RST       = 8'h01;
    localparam logic [7:0]  STAMP_RST       = 8'h00;
    localparam logic [7:0]  ZERO_BYTE       = 8'h00;

    // Calendar and alarm bank, index 0 is seconds
    typedef logic [N_ALARM-1:0][7:0] rtcat_cal_t;
    typedef logic [N_STAMP-1:0][7:0] rtcat_stamp_t;

    // Byte register port from the serial interface
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtcat_req_s;

    // Whole state of the block
    typedef struct packed {
        rtcat_cal_t         alarm;
        rtcat_stamp_t       stamp;
        logic               stamp_taken;
        logic               alarm_flag;
        logic               auto_clear_on_read;
        logic               im;
        logic [FO_W-1:0]    fo;
        logic [PULSE_W-1:0] pulse_cnt;
        logic               batt_prev;
        logic [7:0]         rdata;
    } rtcat_state_s;

endpackage : rtcat_pkg

// ==== testbench/rtcat_host_model.sv ====
// Purpose: Host side of the register port, as the far-side partner
// Assumes: One-cycle strobes, read data registered on the taking edge itself
// Notes:   The bench calls these tasks; address and data are scrambled when idle
`timescale 1ns/1ps
module rtcat_host_model (
    // Clock
    input  wire logic                   clk,
    // Register port
    output rtcat_pkg::rtcat_req_s       req,
    input  wire logic [7:0]             rdata
);
    // Idle port from time zero
    initial req = '0;

    // One access; a released bus shows inverted values so stale data never matches
    task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        #1 q = rdata;
    endtask : acc

    // Clearing a single-event alarm is a write of zero
    task automatic clr_alarm;
        logic [7:0] q;
        acc(1'b1, rtcat_pkg::ADDR_STATUS, 8'h00, q);
    endtask : clr_alarm

    // Stamp clear also re-arms capture
    task automatic clr_stamp;
        logic [7:0] q;
        acc(1'b1, rtcat_pkg::ADDR_SUPPLY, 8'h80, q);
    endtask : clr_stamp

    // All-zero bank means nothing recorded
    function automatic logic recorded(input rtcat_pkg::rtcat_stamp_t s);
        return s != '0;
    endfunction : recorded
endmodule : rtcat_host_model

// ==== testbench/rtc_alarm_and_timestamp_test.sv ====
// Purpose: Self-checking bench for alarm compare and switchover stamp
// Assumes: Seeded random calendars with directed corner cases
// Notes:   fout_wave is driven only in the frequency-select scenario
`timescale 1ns/1ps
module rtc_alarm_and_timestamp_test;
    logic                  clk = 0, sys_rst = 1, sec_tick = 0, on_battery = 0, fout_wave = 0;
    rtcat_pkg::rtcat_cal_t cal_now = '0;
    rtcat_pkg::rtcat_req_s req;
    logic [7:0]            rdata, q;
    logic                  pin_out, pin_oe;
    int                    n_errors = 0, samples_checked = 0, cycles = 0;
    wire                   pin = pin_oe ? 1'b0 : 1'b1; // Pull-up on the open-drain pin

    rtcat_host_model host (.clk(clk), .req(req), .rdata(rdata));
    rtcat_alarm_stamp dut (.clk(clk), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata),
        .sec_tick(sec_tick), .cal_now(cal_now), .on_battery(on_battery), .fout_wave(fout_wave),
        .irq_pin_in(pin), .irq_pin_out(pin_out), .irq_pin_oe(pin_oe));

    // Clock
    initial forever #12.5 clk = ~clk;

    // Verdict and end of run
    task automatic end_sim;
        $display("checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // Hang guard, well above the expected run of about a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end

    // Compare tasks
    task automatic chk8(input string nm, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", nm, e, g);
            n_errors++;
        end
    endtask : chk8
    task automatic chk1(input string nm, input logic e, g);
        chk8(nm, {7'b0, e}, {7'b0, g});
    endtask : chk1

    // Register and calendar helpers
    task automatic rd(input logic [7:0] a);
        host.acc(1'b0, a, 8'h00, q);
    endtask : rd
    task automatic wr(input logic [7:0] a, d);
        host.acc(1'b1, a, d, q);
    endtask : wr
    task automatic tick(input rtcat_pkg::rtcat_cal_t c);
        @(posedge clk);
        sec_tick <= 1'b1;
        cal_now  <= c;
        @(posedge clk);
        sec_tick <= 1'b0;
        #1;
    endtask : tick
    task automatic batt(input rtcat_pkg::rtcat_cal_t c);
        @(posedge clk);
        on_battery <= 1'b0;
        @(posedge clk);
        on_battery <= 1'b1;
        cal_now    <= c;
        @(posedge clk);
    endtask : batt
    task automatic chk_stamp(input rtcat_pkg::rtcat_cal_t c);
        rtcat_pkg::rtcat_stamp_t s;
        for (int i = 0; i < 5; i++) begin
            rd(rtcat_pkg::ADDR_STAMP_BASE + 8'(i));
            s[i] = q;
            chk8("stamp byte", c[i], q);
        end
        chk1("stamp seen", c[4:0] != '0, host.recorded(s));
    endtask : chk_stamp

    // Expected trigger: some field enabled and every enabled field equal on bits 6:0
    function automatic logic hit(input rtcat_pkg::rtcat_cal_t a, c);
        logic any = 0, ok = 1;
        for (int i = 0; i < 6; i++) if (a[i][7]) begin
            any = 1;
            if (a[i][6:0] != c[i][6:0]) ok = 0;
        end
        return any && ok;
    endfunction : hit

    // Main sequence
    initial begin
        rtcat_pkg::rtcat_cal_t al, c;
        int n;
        void'($urandom(78812));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        wr(rtcat_pkg::ADDR_STAMP_BASE, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            rd(rtcat_pkg::ADDR_ALARM_BASE + 8'(i));
            chk8("alarm reset", rtcat_pkg::ALARM_RST, q);
        end
        chk_stamp('0);
        rd(8'h30);
        chk8("unmapped", 8'h00, q);
        tick({6{8'h01}});
        chk1("no enable", 1'b0, pin_oe);
        // Random alarm sets, first pass fully enabled and equal
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 6; i++) begin
                c[i] = 8'($urandom) & 8'h7F;
                al[i][7]   = (k == 0) || ($urandom % 2 == 1);
                al[i][6:0] = ((k == 0) || ($urandom % 2 == 1)) ? c[i][6:0] : 7'($urandom);
                wr(rtcat_pkg::ADDR_ALARM_BASE + 8'(i), al[i]);
            end
            tick(c);
            chk1("pin low", hit(al, c), pin === 1'b0);
            chk1("pin out", 1'b0, pin_out);
            rd(rtcat_pkg::ADDR_STATUS);
            chk8("status", {3'b0, hit(al, c), 4'b0}, q);
            if (hit(al, c)) begin
                repeat (30) @(posedge clk);
                #1 chk1("held low", 1'b1, pin_oe);
                host.clr_alarm();
                chk1("cleared", 1'b0, pin_oe);
            end
        end
        // Auto clear on status read; the read returns the flag before clearing
        // Directed full match so every later mode check really triggers
        for (int i = 0; i < 6; i++) begin
            wr(rtcat_pkg::ADDR_ALARM_BASE + 8'(i), {1'b1, c[i][6:0]});
        end
        wr(rtcat_pkg::ADDR_INT_CTRL, 8'h80);
        tick(c);
        rd(rtcat_pkg::ADDR_STATUS);
        chk8("status auto_clear_on_read", 8'h10, q);
        chk1("auto_clear_on_read pin", 1'b0, pin_oe);
        // Pulsed mode, two matches with no clear between
        wr(rtcat_pkg::ADDR_INT_CTRL, 8'h40);
        repeat (2) begin
            tick(c);
            n = 0;
            while (pin === 1'b0 && n < 100) begin
                @(posedge clk);
                #1 n++;
            end
            chk8("pulse len", 8'(rtcat_pkg::PULSE_CYC), 8'(n));
        end
        rd(rtcat_pkg::ADDR_STATUS);
        chk8("pulsed flag", 8'h10, q);
        // Frequency select owns the pin; a match sets the flag but cannot pull it low
        wr(rtcat_pkg::ADDR_INT_CTRL, 8'h01);
        rd(rtcat_pkg::ADDR_INT_CTRL);
        chk8("ctrl readback", 8'h01, q);
        @(posedge clk);
        fout_wave <= 1'b1;
        tick(c);
        chk1("freq high", 1'b0, pin_oe);
        @(posedge clk);
        fout_wave <= 1'b0;
        #1 chk1("freq low", 1'b1, pin_oe);
        wr(rtcat_pkg::ADDR_INT_CTRL, 8'h00);
        chk1("single again", 1'b1, pin_oe);
        host.clr_alarm();
        chk1("freq cleared", 1'b0, pin_oe);
        chk1("pin out idle", 1'b0, pin_out);
        // Stamp: first switchover only, then clear and re-arm
        batt(c);
        chk_stamp(c);
        batt(~c & {6{8'h7F}});
        chk_stamp(c);
        host.clr_stamp();
        chk_stamp('0);
        batt(~c & {6{8'h7F}});
        chk_stamp(~c & {6{8'h7F}});
        end_sim();
    end
endmodule : rtc_alarm_and_timestamp_test
